// ---- bench/scs_clock_ctrl_test.sv ----
// self-checking bench for clock source selection and oscillator control
`timescale 1ns/10ps
`include "scs_consts.svh"
module scs_clock_ctrl_test
    import scs_pkg::*;
;
    logic        clk_sys;
    logic        rst;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        int_osc_tick;
    logic        xtal_osc_tick;
    logic        low_osc_running;
    logic        int_osc_enable;
    logic        low_osc_enable;
    logic        xtal_osc_enable;
    logic        int_clock_ready;
    logic        xtal_clock_ready;
    logic        fast_clock_choice;
    logic        system_clock_choice;
    logic        cpu_run;
    int          n_fail;
    int          checked;

    scs_clock_ctrl dut_u (
        .clk_sys             (clk_sys),
        .rst                 (rst),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .int_osc_tick        (int_osc_tick),
        .xtal_osc_tick       (xtal_osc_tick),
        .low_osc_running     (low_osc_running),
        .int_osc_enable      (int_osc_enable),
        .low_osc_enable      (low_osc_enable),
        .xtal_osc_enable     (xtal_osc_enable),
        .int_clock_ready     (int_clock_ready),
        .xtal_clock_ready    (xtal_clock_ready),
        .fast_clock_choice   (fast_clock_choice),
        .system_clock_choice (system_clock_choice),
        .cpu_run             (cpu_run)
    );

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    // compare one value and count it
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one-cycle register write
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        #1; // let the registered write settle before callers look
    endtask

    // one-cycle read, data sampled in the following cycle only
    task automatic rd_chk(input string name, input logic [15:0] addr, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask

    // count cycles until a gate opens; ticks arrive every cycle
    task automatic wait_ready(input logic xtal, input int n);
        int c;
        c = 0;
        while (((xtal ? xtal_clock_ready : int_clock_ready) !== 1'b1) && c < 2000) begin
            @(posedge clk_sys);
            #1; // sample the gate after the edge has updated it
            c++;
        end
        checked++;
        if (c < n - 3 || c > n + 3) begin
            n_fail++;
            $display("mismatch settle_cycles expected %0d seen %0d", n, c);
        end
    endtask

    task automatic print_verdict;
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog for a hung handshake or gate
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        print_verdict();
    end

    // main sequence
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        int_osc_tick = 1'b1;
        xtal_osc_tick = 1'b1;
        low_osc_running = 1'b0;
        n_fail = 0;
        checked = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("cpu_run_reset", 8'h00, {7'h00, cpu_run});
        wait_ready(1'b0, 64);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("cpu_run_up", 8'h01, {7'h00, cpu_run});
        rd_chk("src_reset", `SCS_OFF_SRC, `SCS_SRC_RESET);
        rd_chk("ctl_reset", `SCS_OFF_CTL, `SCS_CTL_RESET);
        rd_chk("unmapped", 16'h5062, 8'h00);
        // fast and system choice refused with crystal and low-speed off
        wr(`SCS_OFF_SRC, 8'h02);
        rd_chk("src_fast_refused", `SCS_OFF_SRC, 8'h00);
        wr(`SCS_OFF_SRC, 8'h01);
        rd_chk("src_sys_refused", `SCS_OFF_SRC, 8'h00);
        // internal feeds the system clock and cannot stop
        wr(`SCS_OFF_CTL, 8'h00);
        rd_chk("ctl_keep_int", `SCS_OFF_CTL, 8'h04);
        // crystal on with the shortest settle count
        wr(`SCS_OFF_CTL, 8'h35);
        chk("xtal_en", 8'h01, {7'h00, xtal_osc_enable});
        wait_ready(1'b1, 128);
        wr(`SCS_OFF_SRC, 8'h02);
        rd_chk("src_fast_ok", `SCS_OFF_SRC, 8'h02);
        chk("fast_pin", 8'h01, {7'h00, fast_clock_choice});
        // crystal now feeds the system, internal may stop
        wr(`SCS_OFF_CTL, 8'h31);
        rd_chk("ctl_int_off", `SCS_OFF_CTL, 8'h31);
        chk("int_ready_off", 8'h00, {7'h00, int_clock_ready});
        // low-speed enabled but not running: switch refused
        wr(`SCS_OFF_CTL, 8'h33);
        chk("low_en", 8'h01, {7'h00, low_osc_enable});
        wr(`SCS_OFF_SRC, 8'h03);
        rd_chk("src_low_notrun", `SCS_OFF_SRC, 8'h02);
        low_osc_running <= 1'b1;
        wr(`SCS_OFF_SRC, 8'h03);
        rd_chk("src_low_ok", `SCS_OFF_SRC, 8'h03);
        chk("sys_pin", 8'h01, {7'h00, system_clock_choice});
        // low-speed feeds system: cannot stop; crystal may stop
        wr(`SCS_OFF_CTL, 8'h31);
        rd_chk("ctl_keep_low", `SCS_OFF_CTL, 8'h33);
        wr(`SCS_OFF_CTL, 8'h02);
        rd_chk("ctl_xtal_off", `SCS_OFF_CTL, 8'h02);
        chk("xtal_ready_off", 8'h00, {7'h00, xtal_clock_ready});
        // internal restart with settle selections 3 (8 cycles) and 2 (16 cycles)
        wr(`SCS_OFF_CTL, 8'hC6);
        wait_ready(1'b0, 8);
        wr(`SCS_OFF_CTL, 8'h02);
        wr(`SCS_OFF_CTL, 8'h86);
        wait_ready(1'b0, 16);
        // internal only but choice still crystal: both bits refused
        wr(`SCS_OFF_SRC, 8'h00);
        rd_chk("src_mismatch", `SCS_OFF_SRC, 8'h03);
        // crystal back on with count 512, then switch to internal
        wr(`SCS_OFF_CTL, 8'h97);
        wait_ready(1'b1, 512);
        wr(`SCS_OFF_SRC, 8'h01);
        rd_chk("src_int_sel", `SCS_OFF_SRC, 8'h01);
        wr(`SCS_OFF_SRC, 8'h00);
        rd_chk("src_back_fast", `SCS_OFF_SRC, 8'h00);
        wr(`SCS_OFF_CTL, 8'h03);
        rd_chk("ctl_keep_int2", `SCS_OFF_CTL, 8'h07);
        print_verdict();
    end
endmodule

// ---- rtl/scs_clock_ctrl.sv ----
// system clock source selection and oscillator control
// How it works
// - source bit1 picks fast clock: crystal/internal
// - fast choice changes only with both fast oscillators
// - source bit0 picks system clock: low-speed/fast
// - system switch needs low-speed and fast running
// - fast choice must match running fast oscillator
// - oscillator feeding system clock cannot stop
// - bits 7:6 pick internal settle count 8-64
// - internal clock withheld until settle count ends
// - cpu held after reset for internal settle
// - bits 5:4 pick crystal settle count 128-1024
// - crystal clock withheld until settle count ends
// - crystal settle defaults to 1024 cycles
// - control bits 2:0 enable internal, low, crystal
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`include "scs_consts.svh"
module scs_clock_ctrl
    import scs_pkg::*;
#(
    parameter int ADDR_W = `SCS_ADDR_W
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              int_osc_tick,
    input  wire logic              xtal_osc_tick,
    input  wire logic              low_osc_running,
    output logic                   int_osc_enable,
    output logic                   low_osc_enable,
    output logic                   xtal_osc_enable,
    output logic                   int_clock_ready,
    output logic                   xtal_clock_ready,
    output logic                   fast_clock_choice,
    output logic                   system_clock_choice,
    output logic                   cpu_run
);
    scs_src_s         src_reg;
    scs_ctl_s         ctl_reg;
    scs_ctl_s         ctl_next;
    logic [7:0]       rdata_reg;
    logic             run_reg;
    logic [`SCS_CNT_W-1:0] int_target;
    logic [`SCS_CNT_W-1:0] xtal_target;
    logic             wr_src;
    logic             wr_ctl;
    logic             fast_running;
    logic             fast_ok;
    logic             sys_ok;
    logic             new_fast;
    logic             new_sys;

    assign wr_src = reg_wr && (reg_addr == ADDR_W'(`SCS_OFF_SRC));
    assign wr_ctl = reg_wr && (reg_addr == ADDR_W'(`SCS_OFF_CTL));
    assign new_fast = reg_wdata[`SCS_SRC_FAST_BIT];
    assign new_sys  = reg_wdata[`SCS_SRC_SYS_BIT];

    // fast clock running means the chosen fast oscillator has settled
    assign fast_running = src_reg.fast_clock_choice ? xtal_clock_ready : int_clock_ready;

    // fast choice may change only with both fast oscillators on
    assign fast_ok = ctl_reg.internal_oscillator_on && ctl_reg.crystal_oscillator_on;

    // system switch needs low-speed on and a fast choice matching what runs
    always_comb begin
        sys_ok = 1'b0;
        if (ctl_reg.low_speed_oscillator_on && low_osc_running) begin
            if (ctl_reg.internal_oscillator_on && ctl_reg.crystal_oscillator_on) begin
                sys_ok = 1'b1;
            end else if (ctl_reg.internal_oscillator_on) begin
                sys_ok = !src_reg.fast_clock_choice;
            end else if (ctl_reg.crystal_oscillator_on) begin
                sys_ok = src_reg.fast_clock_choice;
            end
        end
        sys_ok = sys_ok && fast_running;
    end

    // source select register, refused writes keep the old value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            src_reg <= scs_src_s'(`SCS_SRC_RESET);
        end else if (wr_src) begin
            if (fast_ok) begin
                src_reg.fast_clock_choice <= new_fast;
            end
            if (sys_ok) begin
                src_reg.system_clock_choice <= new_sys;
            end
        end
    end

    // next control value with the system clock source protected
    always_comb begin
        ctl_next.internal_settle_select  = reg_wdata[`SCS_CTL_INT_LO +: 2];
        ctl_next.crystal_settle_select   = reg_wdata[`SCS_CTL_XTAL_LO +: 2];
        ctl_next.internal_oscillator_on  = reg_wdata[`SCS_CTL_INT_EN];
        ctl_next.low_speed_oscillator_on = reg_wdata[`SCS_CTL_LOW_EN];
        ctl_next.crystal_oscillator_on   = reg_wdata[`SCS_CTL_XTAL_EN];
        if (src_reg.system_clock_choice) begin
            ctl_next.low_speed_oscillator_on = 1'b1;
        end else if (src_reg.fast_clock_choice) begin
            ctl_next.crystal_oscillator_on = 1'b1;
        end else begin
            ctl_next.internal_oscillator_on = 1'b1;
        end
    end

    // oscillation control register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_reg <= scs_ctl_s'(`SCS_CTL_RESET);
        end else if (wr_ctl) begin
            ctl_reg <= ctl_next;
        end
    end

    // settle count decode for the internal oscillator
    always_comb begin
        case (ctl_reg.internal_settle_select)
            2'h3:    int_target = `SCS_INT_SETTLE_3;
            2'h2:    int_target = `SCS_INT_SETTLE_2;
            2'h1:    int_target = `SCS_INT_SETTLE_1;
            default: int_target = `SCS_INT_SETTLE_0;
        endcase
    end

    // settle count decode for the crystal oscillator
    always_comb begin
        case (ctl_reg.crystal_settle_select)
            2'h3:    xtal_target = `SCS_XTAL_SETTLE_3;
            2'h2:    xtal_target = `SCS_XTAL_SETTLE_2;
            2'h1:    xtal_target = `SCS_XTAL_SETTLE_1;
            default: xtal_target = `SCS_XTAL_SETTLE_0;
        endcase
    end

    // one settle gate per fast oscillator
    scs_settle #(.CNT_W(`SCS_CNT_W)) u_int_settle (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .osc_on   (ctl_reg.internal_oscillator_on),
        .osc_tick (int_osc_tick),
        .target   (int_target),
        .ready    (int_clock_ready)
    );

    scs_settle #(.CNT_W(`SCS_CNT_W)) u_xtal_settle (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .osc_on   (ctl_reg.crystal_oscillator_on),
        .osc_tick (xtal_osc_tick),
        .target   (xtal_target),
        .ready    (xtal_clock_ready)
    );

    // cpu released once the selected system clock has settled after reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            run_reg <= 1'b0;
        end else if (!run_reg) begin
            if (src_reg.system_clock_choice ? low_osc_running : fast_running) begin
                run_reg <= 1'b1;
            end
        end
    end

    // read data one cycle after the strobe, reserved bits zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd && reg_addr == ADDR_W'(`SCS_OFF_SRC)) begin
            rdata_reg <= {6'h00, src_reg};
        end else if (reg_rd && reg_addr == ADDR_W'(`SCS_OFF_CTL)) begin
            rdata_reg <= {ctl_reg[6:3], 1'b0, ctl_reg[2:0]};
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata           = rdata_reg;
    assign int_osc_enable      = ctl_reg.internal_oscillator_on;
    assign low_osc_enable      = ctl_reg.low_speed_oscillator_on;
    assign xtal_osc_enable     = ctl_reg.crystal_oscillator_on;
    assign fast_clock_choice   = src_reg.fast_clock_choice;
    assign system_clock_choice = src_reg.system_clock_choice;
    assign cpu_run             = run_reg;

    // refused fast choice write leaves the bit unchanged
    a_fast_refused: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_src && !fast_ok) |=> $stable(fast_clock_choice))
        else $error("fast choice changed without both oscillators");

    // refused system choice write leaves the bit unchanged
    a_sys_refused: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_src && !sys_ok) |=> $stable(system_clock_choice))
        else $error("system choice changed while switch not allowed");

    // accepted fast choice write takes the written value
    a_fast_taken: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_src && fast_ok) |=> fast_clock_choice == $past(new_fast))
        else $error("fast choice write lost");

    // internal only: system switch needs fast choice zero
    a_match_int: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_src && !ctl_reg.crystal_oscillator_on && src_reg.fast_clock_choice)
        |=> $stable(system_clock_choice))
        else $error("switch allowed with mismatched fast choice");

    // low-speed or internal oscillator on system clock stays enabled
    a_src_kept: assert property (@(posedge clk_sys) disable iff (rst)
        system_clock_choice |-> low_osc_enable)
        else $error("low-speed oscillator stopped while feeding system");

    a_int_kept: assert property (@(posedge clk_sys) disable iff (rst)
        (!system_clock_choice && !fast_clock_choice) |-> int_osc_enable)
        else $error("internal oscillator stopped while feeding system");

    // reserved bit 3 of control reads is zero
    a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == ADDR_W'(`SCS_OFF_CTL)) |=> reg_rdata[3] == 1'b0)
        else $error("reserved bit read as one");

    // cpu held while the fast clock has not settled after reset
    a_cpu_held: assert property (@(posedge clk_sys) disable iff (rst)
        (!run_reg && !system_clock_choice && !fast_running) |=> !cpu_run)
        else $error("cpu released before settle");
endmodule

// ---- rtl/scs_consts.svh ----
// register offsets, field positions, reset values and settle counts for the clock source block
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
`define SCS_ADDR_W          16
`define SCS_OFF_SRC         16'h5060
`define SCS_OFF_CTL         16'h5061
`define SCS_SRC_SYS_BIT     0
`define SCS_SRC_FAST_BIT    1
`define SCS_CTL_XTAL_EN     0
`define SCS_CTL_LOW_EN      1
`define SCS_CTL_INT_EN      2
`define SCS_CTL_XTAL_LO     4
`define SCS_CTL_INT_LO      6
`define SCS_SRC_RESET       8'h00
`define SCS_CTL_RESET       8'h04
`define SCS_INT_SETTLE_3    11'h008
`define SCS_INT_SETTLE_2    11'h010
`define SCS_INT_SETTLE_1    11'h020
`define SCS_INT_SETTLE_0    11'h040
`define SCS_XTAL_SETTLE_3   11'h080
`define SCS_XTAL_SETTLE_2   11'h100
`define SCS_XTAL_SETTLE_1   11'h200
`define SCS_XTAL_SETTLE_0   11'h400
`define SCS_CNT_W           11
`endif

// ---- rtl/scs_pkg.sv ----
// types shared by the clock source block
package scs_pkg;
    typedef struct packed {
        logic fast_clock_choice;
        logic system_clock_choice;
    } scs_src_s;
    typedef struct packed {
        logic [1:0] internal_settle_select;
        logic [1:0] crystal_settle_select;
        logic       internal_oscillator_on;
        logic       low_speed_oscillator_on;
        logic       crystal_oscillator_on;
    } scs_ctl_s;
    typedef enum logic [1:0] {
        SCS_OFF    = 2'h0,
        SCS_SETTLE = 2'h1,
        SCS_READY  = 2'h3
    } scs_settle_e;
endpackage

// ---- rtl/scs_settle.sv ----
// settle counter that gates one oscillator until its start-up count elapses
`timescale 1ns/10ps
`include "scs_consts.svh"
module scs_settle
    import scs_pkg::*;
#(
    parameter int CNT_W = `SCS_CNT_W
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             osc_on,
    input  wire logic             osc_tick,
    input  wire logic [CNT_W-1:0] target,
    output logic                  ready
);
    scs_settle_e      state_reg;
    logic [CNT_W-1:0] count_reg;
    logic             on_d_reg;

    // previous enable for rising edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            on_d_reg <= 1'b0;
        end else begin
            on_d_reg <= osc_on;
        end
    end

    // restart on enable rise, count oscillator ticks, open at target
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= SCS_OFF;
            count_reg <= '0;
        end else begin
            case (state_reg)
                SCS_OFF: begin
                    count_reg <= '0;
                    if (osc_on && !on_d_reg) begin
                        state_reg <= SCS_SETTLE;
                    end
                end
                SCS_SETTLE: begin
                    if (!osc_on) begin
                        state_reg <= SCS_OFF;
                    end else if (osc_tick) begin
                        count_reg <= CNT_W'(count_reg + 1'b1);
                        if (CNT_W'(count_reg + 1'b1) >= target) begin
                            state_reg <= SCS_READY;
                        end
                    end
                end
                SCS_READY: begin
                    if (!osc_on) begin
                        state_reg <= SCS_OFF;
                    end
                end
                default: state_reg <= SCS_OFF;
            endcase
        end
    end

    assign ready = (state_reg == SCS_READY) && osc_on;

    // gate stays shut for two cycles after a start
    a_gate_held: assert property (@(posedge clk_sys) disable iff (rst)
        (osc_on && !on_d_reg && state_reg == SCS_OFF) |=> !ready [*2])
        else $error("clock gate opened right after start");
endmodule
